// >>> verilog/eirq_top.v
// external interrupt inputs: pin select, polarity, edge/level sense, pending flags
`timescale 1ns/1ps
`include "eirq_map.vh"
module eirq_top #(
    parameter PINS = 8
) (
    input  wire            clk_i,          // system clock, 200 MHz
    input  wire            srst_i,         // synchronous reset, active high
    input  wire [7:0]      wb_adr_i,       // wishbone byte address
    input  wire [31:0]     wb_dat_i,       // wishbone write data
    output wire [31:0]     wb_dat_o,       // wishbone read data
    input  wire            wb_we_i,        // wishbone write enable
    input  wire [3:0]      wb_sel_i,       // wishbone byte selects
    input  wire            wb_stb_i,       // wishbone strobe
    input  wire            wb_cyc_i,       // wishbone cycle
    output wire            wb_ack_o,       // wishbone acknowledge
    input  wire [PINS-1:0] port_zero_i,    // port 0 pin levels
    input  wire [PINS-1:0] port_zero_skip_reg_i, // crossbar skip bits
    input  wire [PINS-1:0] xbar_req_i,     // crossbar wants the pin for a peripheral
    output wire [PINS-1:0] xbar_grant_o,   // crossbar may hand the pin out
    input  wire            vector_zero_i,  // CPU vectors to interrupt zero routine
    input  wire            vector_one_i,   // CPU vectors to interrupt one routine
    output wire            irq_zero_req_o, // request to CPU, interrupt zero
    output wire            irq_one_req_o,  // request to CPU, interrupt one
    output wire            irq_zero_priority_o, // priority of interrupt zero
    output wire            irq_one_priority_o   // priority of interrupt one
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ACK  = 2'b10;

    reg  [7:0]      ext_int_pin_config_q;
    reg  [6:0]      ctrl_q;
    reg             irq_zero_pending_q;
    reg             irq_one_pending_q;
    reg             zero_act_q;
    reg             one_act_q;
    reg  [1:0]      bus_st_q;
    reg  [1:0]      bus_st_d;
    reg  [31:0]     rdata_q;
    reg  [31:0]     rdata_d;
    wire [PINS-1:0] pin_sync;
    wire [2:0]      irq_zero_pin_sel;
    wire [2:0]      irq_one_pin_sel;
    wire            irq_zero_polarity;
    wire            irq_one_polarity;
    wire            irq_zero_edge_sel;
    wire            irq_one_edge_sel;
    wire            zero_pin;
    wire            one_pin;
    wire            zero_act;
    wire            one_act;
    wire            zero_rise;
    wire            one_rise;
    wire            zero_flag;
    wire            one_flag;
    wire            req;
    wire            wr_hit;

    eirq_sync #(
        .W (PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (port_zero_i),
        .sync_o  (pin_sync)
    );

    assign xbar_grant_o = xbar_req_i & ~port_zero_skip_reg_i;

    assign irq_zero_pin_sel  = ext_int_pin_config_q[`EIRQ_CFG_ZERO_SEL_HI:`EIRQ_CFG_ZERO_SEL_LO];
    assign irq_one_pin_sel   = ext_int_pin_config_q[`EIRQ_CFG_ONE_SEL_HI:`EIRQ_CFG_ONE_SEL_LO];
    assign irq_zero_polarity = ext_int_pin_config_q[`EIRQ_CFG_ZERO_POL];
    assign irq_one_polarity  = ext_int_pin_config_q[`EIRQ_CFG_ONE_POL];
    assign irq_zero_edge_sel = ctrl_q[`EIRQ_CTL_ZERO_EDGE];
    assign irq_one_edge_sel  = ctrl_q[`EIRQ_CTL_ONE_EDGE];

    // observe only, no drive; codes above PINS-1 read a high pin, inactive only when polarity is low
    assign zero_pin = ({29'h0, irq_zero_pin_sel} < PINS) ? pin_sync[irq_zero_pin_sel] : 1'b1;
    assign one_pin  = ({29'h0, irq_one_pin_sel} < PINS) ? pin_sync[irq_one_pin_sel] : 1'b1;

    assign zero_act = ~(zero_pin ^ irq_zero_polarity);
    assign one_act  = ~(one_pin ^ irq_one_polarity);

    assign zero_rise = zero_act & ~zero_act_q;
    assign one_rise  = one_act & ~one_act_q;

    // previous active level; polarity change may itself look like an edge
    always @(posedge clk_i) begin
        if (srst_i) begin
            zero_act_q <= 1'b0;
            one_act_q  <= 1'b0;
        end else begin
            zero_act_q <= zero_act;
            one_act_q  <= one_act;
        end
    end

    // edge latch, set beats vector clear
    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_zero_pending_q <= 1'b0;
            irq_one_pending_q  <= 1'b0;
        end else begin
            if (irq_zero_edge_sel && zero_rise) begin
                irq_zero_pending_q <= 1'b1;
            end else if (vector_zero_i || !irq_zero_edge_sel) begin
                irq_zero_pending_q <= 1'b0;
            end
            if (irq_one_edge_sel && one_rise) begin
                irq_one_pending_q <= 1'b1;
            end else if (vector_one_i || !irq_one_edge_sel) begin
                irq_one_pending_q <= 1'b0;
            end
        end
    end

    assign zero_flag = irq_zero_edge_sel ? irq_zero_pending_q : zero_act;
    assign one_flag  = irq_one_edge_sel ? irq_one_pending_q : one_act;

    assign irq_zero_req_o = zero_flag & ctrl_q[`EIRQ_CTL_ZERO_EN] & ctrl_q[`EIRQ_CTL_GLOBAL_EN];
    assign irq_one_req_o  = one_flag & ctrl_q[`EIRQ_CTL_ONE_EN] & ctrl_q[`EIRQ_CTL_GLOBAL_EN];
    assign irq_zero_priority_o = ctrl_q[`EIRQ_CTL_ZERO_PRIO];
    assign irq_one_priority_o  = ctrl_q[`EIRQ_CTL_ONE_PRIO];

    // bus slave: ack one cycle after request, dropped the next cycle
    assign req    = wb_cyc_i & wb_stb_i;
    assign wr_hit = (bus_st_q == ST_IDLE) & req & wb_we_i & wb_sel_i[0];

    always @* begin
        case (bus_st_q)
            ST_IDLE: bus_st_d = req ? ST_ACK : ST_IDLE;
            ST_ACK:  bus_st_d = ST_IDLE;
            default: bus_st_d = ST_IDLE;
        endcase
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `EIRQ_OFF_PIN_CONFIG: rdata_d[7:0] = ext_int_pin_config_q;
            `EIRQ_OFF_CTRL:       rdata_d[6:0] = ctrl_q;
            `EIRQ_OFF_STATUS: begin
                rdata_d[`EIRQ_ST_ZERO_PEND] = zero_flag;
                rdata_d[`EIRQ_ST_ONE_PEND]  = one_flag;
                rdata_d[`EIRQ_ST_ZERO_PIN]  = zero_pin;
                rdata_d[`EIRQ_ST_ONE_PIN]   = one_pin;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            bus_st_q <= ST_IDLE;
            rdata_q  <= 32'h0000_0000;
        end else begin
            bus_st_q <= bus_st_d;
            rdata_q  <= rdata_d;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            ext_int_pin_config_q <= `EIRQ_RST_PIN_CONFIG;
            ctrl_q               <= `EIRQ_RST_CTRL;
        end else if (wr_hit) begin
            if (wb_adr_i == `EIRQ_OFF_PIN_CONFIG) begin
                ext_int_pin_config_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `EIRQ_OFF_CTRL) begin
                ctrl_q <= wb_dat_i[6:0];
            end
        end
    end

    assign wb_ack_o = (bus_st_q == ST_ACK);
    assign wb_dat_o = rdata_q;
endmodule // eirq_top

// >>> verilog/eirq_map.vh
// register offsets, field positions and reset values of the external interrupt block
`ifndef EIRQ_MAP_VH
`define EIRQ_MAP_VH
`define EIRQ_ADDR_W            8
`define EIRQ_OFF_PIN_CONFIG    8'hE4
`define EIRQ_OFF_CTRL          8'hE8
`define EIRQ_OFF_STATUS        8'hEC
`define EIRQ_RST_PIN_CONFIG    8'h01
`define EIRQ_RST_CTRL          7'h00
`define EIRQ_CFG_ONE_POL       7
`define EIRQ_CFG_ONE_SEL_HI    6
`define EIRQ_CFG_ONE_SEL_LO    4
`define EIRQ_CFG_ZERO_POL      3
`define EIRQ_CFG_ZERO_SEL_HI   2
`define EIRQ_CFG_ZERO_SEL_LO   0
`define EIRQ_CTL_ZERO_EDGE     0
`define EIRQ_CTL_ONE_EDGE      1
`define EIRQ_CTL_ZERO_EN       2
`define EIRQ_CTL_ONE_EN        3
`define EIRQ_CTL_GLOBAL_EN     4
`define EIRQ_CTL_ZERO_PRIO     5
`define EIRQ_CTL_ONE_PRIO      6
`define EIRQ_ST_ZERO_PEND      1
`define EIRQ_ST_ONE_PEND       3
`define EIRQ_ST_ZERO_PIN       4
`define EIRQ_ST_ONE_PIN        5
`endif

// >>> verilog/eirq_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module eirq_sync #(
    parameter W = 8
) (
    input  wire         clk_i,   // system clock
    input  wire         srst_i,  // synchronous reset
    input  wire [W-1:0] async_i, // raw pins
    output wire [W-1:0] sync_o   // filtered, clock-domain level
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    reg [W-1:0] val_q;
    genvar g;
    // port latches reset high, so start all stages high
    always @(posedge clk_i) begin
        if (srst_i) begin
            s1_q <= {W{1'b1}};
            s2_q <= {W{1'b1}};
            s3_q <= {W{1'b1}};
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            // change counts once stages two and three agree
            always @(posedge clk_i) begin
                if (srst_i) begin
                    val_q[g] <= 1'b1;
                end else if (s2_q[g] == s3_q[g]) begin
                    val_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate
    assign sync_o = val_q;
endmodule // eirq_sync

// >>> verification/eirq_src.sv
// port 0 source model: open-drain requesters with pull-ups
`timescale 1ns/1ps
module eirq_src (
    input  wire logic [7:0] drive_low_i, // pull-down request per pin
    output wire logic [7:0] pin_o        // resolved pin level
);
    // open drain, held by the bench for a fixed wait, released pins float high
    assign pin_o = ~drive_low_i;
endmodule // eirq_src

// >>> verification/eirq_top_properties.sv
// concurrent checks on the external interrupt block ports
`timescale 1ns/1ps
module eirq_top_props #(
    parameter PINS = 8
) (
    input wire logic            clk_i,
    input wire logic            srst_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic            wb_we_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_ack_o,
    input wire logic [PINS-1:0] port_zero_i,
    input wire logic [PINS-1:0] port_zero_skip_reg_i,
    input wire logic [PINS-1:0] xbar_req_i,
    input wire logic [PINS-1:0] xbar_grant_o,
    input wire logic            vector_zero_i,
    input wire logic            vector_one_i,
    input wire logic            irq_zero_req_o,
    input wire logic            irq_one_req_o,
    input wire logic            irq_zero_priority_o,
    input wire logic            irq_one_priority_o
);
    logic [7:0] ctl_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // pins quiet long enough that nothing is left in the synchroniser
    sequence s_pins_quiet;
        $stable(port_zero_i) [*6];
    endsequence
    // shadow of the control register, written on the taking edge
    always @(posedge clk_i) begin
        if (srst_i)
            ctl_q <= 8'h00;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == 8'hE8)
            ctl_q <= wb_dat_i[7:0];
    end
    grant_mask_a: assert property (xbar_grant_o == (xbar_req_i & ~port_zero_skip_reg_i))
        else $error("grant not masked by skip bits");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_follow_a: assert property (s_take |=> wb_ack_o)
        else $error("no ack after request");
    reset_quiet_a: assert property ($fell(srst_i) |-> !wb_ack_o && !irq_zero_req_o
        && !irq_one_req_o)
        else $error("activity right after reset");
    irq_gate_a: assert property ((irq_zero_req_o |-> ctl_q[2] && ctl_q[4])
        and (irq_one_req_o |-> ctl_q[3] && ctl_q[4]))
        else $error("request passed a cleared enable");
    prio_track_a: assert property ({irq_one_priority_o, irq_zero_priority_o} == ctl_q[6:5])
        else $error("priority output differs from control");
    edge_clear_a: assert property (s_pins_quiet ##0 (vector_one_i && ctl_q[1])
        |=> !irq_one_req_o)
        else $error("edge flag not cleared by vector");
    zero_clear_a: assert property (s_pins_quiet ##0 (vector_zero_i && ctl_q[0])
        |=> !irq_zero_req_o)
        else $error("zero edge flag not cleared by vector");
    sync_delay_a: assert property (!$stable(port_zero_i) && !wb_cyc_i
        && !vector_zero_i && !vector_one_i |=> $stable({irq_zero_req_o, irq_one_req_o}))
        else $error("pin change reached request unsynchronised");
endmodule // eirq_top_props
bind eirq_top eirq_top_props #(.PINS(PINS)) eirq_top_props_inst (.*);

// >>> verification/eirq_top_test.sv
// self-checking bench for the external interrupt block
`timescale 1ns/1ps
module eirq_top_test;
    logic        clk_i = 1'h0;
    logic        srst_i = 1'h1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic        wb_we_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_cyc_i = 1'h0;
    logic [7:0]  drive_low = 8'h00;
    logic        vec0 = 1'h0;
    logic        vec1 = 1'h0;
    logic [7:0]  rdat;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, req0, req1, prio0, prio1;
    wire  [7:0]  pins, grant;
    int          n_fail = 0;
    int          num_checks = 0;
    always #2.5 clk_i = ~clk_i;
    eirq_src eirq_src_inst (.drive_low_i(drive_low), .pin_o(pins));
    eirq_top #(.PINS(8)) eirq_top_inst (.clk_i(clk_i), .srst_i(srst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'h1),
        .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .port_zero_i(pins),
        .port_zero_skip_reg_i(8'h0F), .xbar_req_i(8'hFF), .xbar_grant_o(grant),
        .vector_zero_i(vec0), .vector_one_i(vec1), .irq_zero_req_o(req0),
        .irq_one_req_o(req1), .irq_zero_priority_o(prio0), .irq_one_priority_o(prio1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one classic cycle; waits for ack, only the watchdog ends a hang
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1);
        rdat = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        // ack stands in the cycle after the taking edge
        chk(n[7:0], 8'h02, "ack latency");
    endtask
    task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string what);
        bus(1'h0, adr, 8'h00);
        chk(rdat, exp, what);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'h0;
        rd(8'hE4, 8'h01, "cfg reset");
        rd(8'hE8, 8'h00, "ctl reset");
        bus(1'h1, 8'hF0, 8'hFF);
        rd(8'hF0, 8'h00, "unmapped");
        chk(grant, 8'hF0, "grant");
        $display("test reset done");
        bus(1'h1, 8'hE8, 8'h1C);
        for (int k = 0; k < 8; k++) begin
            bus(1'h1, 8'hE4, {1'h0, k[2:0], 1'h0, k[2:0]});
            drive_low <= 8'h01 << k;
            repeat (10) @(posedge clk_i);
            chk({6'h0, req1, req0}, 8'h03, "level on");
            rd(8'hEC, 8'h0A, "pending");
            drive_low <= 8'h00;
            repeat (10) @(posedge clk_i);
            chk({6'h0, req1, req0}, 8'h00, "level off");
        end
        $display("test level done");
        drive_low <= 8'h20;
        repeat (6) @(posedge clk_i);
        bus(1'h1, 8'hE4, 8'hD1);
        bus(1'h1, 8'hE8, 8'h5A);
        repeat (10) @(posedge clk_i);
        chk({6'h0, prio1, req1}, 8'h02, "edge idle");
        drive_low <= 8'h00;
        repeat (10) @(posedge clk_i);
        chk({6'h0, prio1, req1}, 8'h03, "edge set");
        vec1 <= 1'h1;
        @(posedge clk_i);
        vec1 <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk({6'h0, prio1, req1}, 8'h02, "vector clear");
        bus(1'h1, 8'hE8, 8'h0A);
        drive_low <= 8'h20;
        repeat (10) @(posedge clk_i);
        drive_low <= 8'h00;
        repeat (10) @(posedge clk_i);
        chk({7'h0, req1}, 8'h00, "masked");
        rd(8'hEC, 8'h38, "pending masked");
        bus(1'h1, 8'hE8, 8'h1A);
        chk({7'h0, req1}, 8'h01, "unmasked");
        bus(1'h1, 8'hE8, 8'h35);
        drive_low <= 8'h02;
        repeat (10) @(posedge clk_i);
        chk({6'h0, prio0, req0}, 8'h03, "zero edge set");
        drive_low <= 8'h00;
        repeat (10) @(posedge clk_i);
        chk({6'h0, prio0, req0}, 8'h03, "zero edge held");
        vec0 <= 1'h1;
        @(posedge clk_i);
        vec0 <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk({6'h0, prio0, req0}, 8'h02, "zero vector clear");
        $display("test edge done");
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_of_test;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
endmodule // eirq_top_test
